/* core/sample_status_output_regs.sv */
`timescale 1ns/1ns
// Summary of operation
// - Queue off: address 00h reads the sample-ready status of 06h.
// - Queue on: address 00h reads the queue status of 0Dh.
// - Mode 00 queue off, 01 circular, 10 stop when full; map follows it.
// - Queue on: 01h is the queue read port and increments to itself.
// - Queue on: addresses 02h to 05h read as zero.
// - Queue off: burst address runs 00h to 05h, then wraps to 00h.
// - Pressure bits 19:12 at 01h, 11:4 at 02h, 3:0 in upper nibble of 03h.
// - Temperature bits 11:4 at 04h, 3:0 in upper nibble of 05h.
// - Status, samples and read data byte are zero at reset and on standby-to-active.
// - Bit 7 sets when any new result overwrites unread data.
// - Queue off: bit 7 clears on reading either high byte.
// - Queue on: overwrite and ready flags clear on a queue port read.
// - Bit 6 sets on unread pressure overwrite; clears on pressure high byte read.
// - Bit 5 sets on unread temperature overwrite; clears on temperature high byte read.
// - Bit 3 sets on any new result; clears on either high byte read.
// - Bit 4 reads zero; all status bits are read-only.
// - Bit 2 sets on each pressure result; clears on pressure high byte read.
// - Bit 1 sets on each temperature result; clears on temperature high byte read.
// - Combined flags need the generator enable; single flags need their own enables.
module sample_status_output_regs
   import sensor_regs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire rd_req_t rd_req_i,
   input wire logic [1:0] queue_mode_i,
   input wire event_flag_config_t cfg_i,
   input wire logic low_power_idle_i,
   input wire sample_evt_t sample_i,
   input wire logic [7:0] queue_status_i,
   input wire logic [7:0] queue_data_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic [7:0] next_addr_o,
   output logic queue_pop_o,
   output logic [7:0] status_o
);

   // auto-increment successor of a read address
   function automatic logic [7:0] next_address(input logic [7:0] addr, input logic queue_on);
      logic [7:0] result;
      result = addr + 8'h01;
      if (queue_on && addr == ADDR_QUEUE_PORT) begin
         result = ADDR_QUEUE_PORT;
      end else if (addr == ADDR_T_LOW) begin
         result = ADDR_ALIAS;
      end
      next_address = result;
   endfunction

   queue_mode_t queue_mode;
   logic queue_on;
   logic rd_en;
   logic [7:0] rd_addr;
   logic hit_alias;
   logic hit_p_high;
   logic hit_p_mid;
   logic hit_p_low;
   logic hit_t_high;
   logic hit_t_low;
   logic hit_status;
   logic hit_queue_status;
   logic read_queue_port;
   logic read_p_high;
   logic read_t_high;
   logic activate;
   logic idle_prev;
   logic [PRESSURE_W-1:0] pressure_sample;
   logic [TEMPERATURE_W-1:0] temperature_sample;
   logic [PRESSURE_W-1:0] next_pressure;
   logic [TEMPERATURE_W-1:0] next_temperature;
   logic [7:0] alias_byte;
   logic [7:0] p_high_byte;
   logic [7:0] p_mid_byte;
   logic [7:0] p_low_byte;
   logic [7:0] t_high_byte;
   logic [7:0] t_low_byte;
   logic [7:0] sel_data;
   logic [7:0] next_rd_data;
   logic clr_pressure;
   logic clr_temperature;
   logic clr_all;

   // mode 11 is undefined; it is treated like any other nonzero mode
   assign queue_mode = queue_mode_t'(queue_mode_i);
   assign queue_on = (queue_mode != QUEUE_OFF);
   assign rd_en = rd_req_i.en;
   assign rd_addr = rd_req_i.addr;

   assign hit_alias = (rd_addr == ADDR_ALIAS);
   assign hit_p_high = (rd_addr == ADDR_P_HIGH);
   assign hit_p_mid = (rd_addr == ADDR_P_MID);
   assign hit_p_low = (rd_addr == ADDR_P_LOW);
   assign hit_t_high = (rd_addr == ADDR_T_HIGH);
   assign hit_t_low = (rd_addr == ADDR_T_LOW);
   assign hit_status = (rd_addr == ADDR_STATUS);
   assign hit_queue_status = (rd_addr == ADDR_QUEUE_STATUS);

   assign read_queue_port = rd_en & hit_p_high & queue_on;
   assign read_p_high = rd_en & hit_p_high & ~queue_on;
   assign read_t_high = rd_en & hit_t_high & ~queue_on;

   // leaving low-power idle starts a fresh session
   assign activate = idle_prev & ~low_power_idle_i;

   assign clr_pressure = read_p_high;
   assign clr_temperature = read_t_high;
   assign clr_all = read_queue_port | activate;

   assign alias_byte = queue_on ? queue_status_i : status_o;
   assign p_high_byte = queue_on ? queue_data_i : pressure_sample[19:12];
   assign p_mid_byte = queue_on ? REG_RESET : pressure_sample[11:4];
   assign p_low_byte = queue_on ? REG_RESET : {pressure_sample[3:0], NIBBLE_ZERO};
   assign t_high_byte = queue_on ? REG_RESET : temperature_sample[11:4];
   assign t_low_byte = queue_on ? REG_RESET : {temperature_sample[3:0], NIBBLE_ZERO};

   // unmapped addresses belong to other register areas and read as zero here
   assign sel_data = hit_alias ? alias_byte :
                     hit_p_high ? p_high_byte :
                     hit_p_mid ? p_mid_byte :
                     hit_p_low ? p_low_byte :
                     hit_t_high ? t_high_byte :
                     hit_t_low ? t_low_byte :
                     hit_status ? status_o :
                     hit_queue_status ? queue_status_i :
                     REG_RESET;
   assign next_rd_data = rd_en ? sel_data : rd_data_o;

   // a result landing in the activation cycle is kept
   assign next_pressure = sample_i.p_done ? sample_i.pressure :
                          activate ? PRESSURE_RESET : pressure_sample;
   assign next_temperature = sample_i.t_done ? sample_i.temperature :
                             activate ? TEMPERATURE_RESET : temperature_sample;

   status_flags u_flags (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .p_done_i(sample_i.p_done),
      .t_done_i(sample_i.t_done),
      .cfg_i(cfg_i),
      .clr_pressure_i(clr_pressure),
      .clr_temperature_i(clr_temperature),
      .clr_all_i(clr_all),
      .status_o(status_o)
   );

   // power-on counts as idle so the first activation also clears
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         idle_prev <= 1'b1;
      end else begin
         idle_prev <= low_power_idle_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pressure_sample <= PRESSURE_RESET;
         temperature_sample <= TEMPERATURE_RESET;
      end else begin
         pressure_sample <= next_pressure;
         temperature_sample <= next_temperature;
      end
   end

   // read data holds until the next read; activation zeroes the last read byte
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= REG_RESET;
      end else if (activate && !rd_en) begin
         rd_data_o <= REG_RESET;
      end else begin
         rd_data_o <= next_rd_data;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         next_addr_o <= ADDR_ALIAS;
      end else if (rd_en) begin
         next_addr_o <= next_address(rd_addr, queue_on);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_valid_o <= 1'b0;
         queue_pop_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_en;
         queue_pop_o <= read_queue_port;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_read(logic [7:0] a);
      rd_en && rd_addr == a;
   endsequence

   sequence s_pressure_evt;
      sample_i.p_done && cfg_i.pressure_event_enable;
   endsequence

   sequence s_stale_pressure;
      s_pressure_evt ##1 s_pressure_evt;
   endsequence

   sequence s_stale_temperature;
      (sample_i.t_done && cfg_i.temperature_event_enable) ##1
      (sample_i.t_done && cfg_i.temperature_event_enable);
   endsequence

   chk_alias_ready_status: assert property (
      (s_read(ADDR_ALIAS) and !queue_on) |=> rd_data_o == $past(status_o))
      else $error("alias did not return sample-ready status");

   chk_alias_queue_status: assert property (
      (s_read(ADDR_ALIAS) and queue_on) |=> rd_data_o == $past(queue_status_i))
      else $error("alias did not return queue status");

   chk_queue_port_stays: assert property (
      (s_read(ADDR_QUEUE_PORT) and queue_on) |=> next_addr_o == ADDR_QUEUE_PORT && queue_pop_o
         ##1 !queue_pop_o || $past(read_queue_port))
      else $error("queue port read did not pop or did not hold address");

   chk_reserved_zero: assert property (
      rd_en && queue_on && rd_addr >= ADDR_P_MID && rd_addr <= ADDR_T_LOW |=> rd_data_o == REG_RESET)
      else $error("reserved address read nonzero with queue on");

   chk_burst_wrap: assert property (
      s_read(ADDR_T_LOW) |=> next_addr_o == ADDR_ALIAS)
      else $error("burst address did not wrap to zero");

   chk_burst_step: assert property (
      (s_read(ADDR_P_MID) and !queue_on) |=> next_addr_o == ADDR_P_LOW && rd_valid_o)
      else $error("burst address did not advance");

   chk_pressure_bytes: assert property (
      (sample_i.p_done && !queue_on) ##1 (s_read(ADDR_P_LOW) and !sample_i.p_done and !queue_on)
         |=> rd_data_o == {$past(sample_i.pressure[3:0], 2), NIBBLE_ZERO})
      else $error("pressure low nibble misplaced");

   chk_temperature_high: assert property (
      (s_read(ADDR_T_HIGH) and !queue_on) |=> rd_data_o == $past(temperature_sample[11:4]))
      else $error("temperature high byte misplaced");

   chk_activate_clear: assert property (
      activate && !sample_i.p_done && !sample_i.t_done && !rd_en
         |=> pressure_sample == PRESSURE_RESET && temperature_sample == TEMPERATURE_RESET
            && rd_data_o == REG_RESET && status_o[BIT_ANY_RDY] == 1'b0)
      else $error("standby to active did not clear outputs");

   chk_any_overwrite: assert property (
      sample_i.p_done && cfg_i.ready_event_generator_enable && status_o[BIT_ANY_RDY]
         |=> status_o[BIT_ANY_OW])
      else $error("combined overwrite not set");

   chk_high_byte_clear: assert property (
      read_t_high && !sample_i.p_done && !sample_i.t_done
         |=> !status_o[BIT_ANY_OW] && !status_o[BIT_ANY_RDY] && !status_o[BIT_T_RDY])
      else $error("temperature high byte read did not clear flags");

   chk_queue_read_clear: assert property (
      read_queue_port && !sample_i.p_done && !sample_i.t_done |=> status_o == REG_RESET)
      else $error("queue port read did not clear flags");

   chk_pressure_overwrite: assert property (
      s_stale_pressure |=> status_o[BIT_P_OW])
      else $error("pressure overwrite not set");

   chk_temperature_overwrite: assert property (
      s_stale_temperature |=> status_o[BIT_T_OW])
      else $error("temperature overwrite not set");

   chk_reserved_bits: assert property (
      status_o[BIT_RSVD_HI] == 1'b0 && status_o[BIT_RSVD_LO] == 1'b0)
      else $error("reserved status bit set");

   chk_ready_gating: assert property (
      sample_i.p_done && !sample_i.t_done && !cfg_i.ready_event_generator_enable
         && !status_o[BIT_ANY_RDY] |=> !status_o[BIT_ANY_RDY])
      else $error("combined ready set with generator disabled");

   chk_set_wins: assert property (
      (s_pressure_evt and s_read(ADDR_P_HIGH)) |=> status_o[BIT_P_RDY])
      else $error("ready flag lost to same-cycle read");

   chk_pressure_ready_clear: assert property (
      read_p_high && !sample_i.p_done |=> !status_o[BIT_P_RDY] && !status_o[BIT_P_OW])
      else $error("pressure high byte read did not clear flags");

   sequence s_temperature_evt;
      sample_i.t_done && cfg_i.temperature_event_enable;
   endsequence

   chk_status_read: assert property (
      s_read(ADDR_STATUS) |=> rd_data_o == $past(status_o))
      else $error("status address did not return the flags");

   chk_queue_status_read: assert property (
      s_read(ADDR_QUEUE_STATUS) |=> rd_data_o == $past(queue_status_i))
      else $error("queue status address returned wrong byte");

   chk_pressure_high: assert property (
      (s_read(ADDR_P_HIGH) and !queue_on) |=> rd_data_o == $past(pressure_sample[19:12]))
      else $error("pressure high byte misplaced");

   chk_pressure_mid: assert property (
      (s_read(ADDR_P_MID) and !queue_on) |=> rd_data_o == $past(pressure_sample[11:4]))
      else $error("pressure middle byte misplaced");

   chk_temperature_low: assert property (
      (s_read(ADDR_T_LOW) and !queue_on) |=> rd_data_o == {$past(temperature_sample[3:0]), NIBBLE_ZERO})
      else $error("temperature low nibble misplaced");

   chk_queue_port_data: assert property (
      (s_read(ADDR_QUEUE_PORT) and queue_on) |=> rd_data_o == $past(queue_data_i))
      else $error("queue port did not return the head byte");

   chk_no_pop: assert property (
      (s_read(ADDR_P_HIGH) and !queue_on) |=> !queue_pop_o)
      else $error("pressure high byte read popped the queue");

   chk_pressure_ready_set: assert property (
      s_pressure_evt |=> status_o[BIT_P_RDY])
      else $error("pressure ready not set");

   chk_temperature_ready_set: assert property (
      s_temperature_evt |=> status_o[BIT_T_RDY])
      else $error("temperature ready not set");

   chk_any_ready_set: assert property (
      (sample_i.p_done || sample_i.t_done) && cfg_i.ready_event_generator_enable |=> status_o[BIT_ANY_RDY])
      else $error("combined ready not set");

   chk_read_answer: assert property (
      rd_en |=> rd_valid_o)
      else $error("read got no answer");

endmodule // sample_status_output_regs

/* core/sensor_regs_pkg.sv */
package sensor_regs_pkg;

   localparam logic [7:0] ADDR_ALIAS = 8'h00;
   localparam logic [7:0] ADDR_P_HIGH = 8'h01;
   localparam logic [7:0] ADDR_P_MID = 8'h02;
   localparam logic [7:0] ADDR_P_LOW = 8'h03;
   localparam logic [7:0] ADDR_T_HIGH = 8'h04;
   localparam logic [7:0] ADDR_T_LOW = 8'h05;
   localparam logic [7:0] ADDR_STATUS = 8'h06;
   localparam logic [7:0] ADDR_QUEUE_STATUS = 8'h0d;
   localparam logic [7:0] ADDR_QUEUE_PORT = 8'h01;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;

   localparam int unsigned BIT_ANY_OW = 7;
   localparam int unsigned BIT_P_OW = 6;
   localparam int unsigned BIT_T_OW = 5;
   localparam int unsigned BIT_RSVD_HI = 4;
   localparam int unsigned BIT_ANY_RDY = 3;
   localparam int unsigned BIT_P_RDY = 2;
   localparam int unsigned BIT_T_RDY = 1;
   localparam int unsigned BIT_RSVD_LO = 0;

   localparam int unsigned PRESSURE_W = 20;
   localparam int unsigned TEMPERATURE_W = 12;
   localparam logic [PRESSURE_W-1:0] PRESSURE_RESET = 20'h0_0000;
   localparam logic [TEMPERATURE_W-1:0] TEMPERATURE_RESET = 12'h000;

   typedef enum logic [1:0] {
      QUEUE_OFF = 2'b00,
      QUEUE_CIRCULAR = 2'b01,
      QUEUE_STOP_FULL = 2'b10,
      QUEUE_UNDEFINED = 2'b11
   } queue_mode_t;

   typedef struct packed {
      logic en;
      logic [7:0] addr;
   } rd_req_t;

   typedef struct packed {
      logic p_done;
      logic [PRESSURE_W-1:0] pressure;
      logic t_done;
      logic [TEMPERATURE_W-1:0] temperature;
   } sample_evt_t;

   typedef struct packed {
      logic pressure_event_enable;
      logic temperature_event_enable;
      logic ready_event_generator_enable;
   } event_flag_config_t;

endpackage

/* core/status_flags.sv */
`timescale 1ns/1ns
module status_flags
   import sensor_regs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic p_done_i,
   input wire logic t_done_i,
   input wire event_flag_config_t cfg_i,
   input wire logic clr_pressure_i,
   input wire logic clr_temperature_i,
   input wire logic clr_all_i,
   output logic [7:0] status_o
);
   function automatic logic next_flag(input logic cur, input logic set, input logic clr);
      // set wins so an acquisition landing on the clearing read is kept
      next_flag = set | (cur & ~clr);
   endfunction

   logic pressure_ready_flag;
   logic temperature_ready_flag;
   logic any_ready_flag;
   logic set_p_rdy;
   logic set_t_rdy;
   logic set_any_rdy;
   logic set_p_ow;
   logic set_t_ow;
   logic set_any_ow;
   logic clr_p;
   logic clr_t;
   logic clr_any;
   logic [7:0] next_status;

   assign pressure_ready_flag = status_o[BIT_P_RDY];
   assign temperature_ready_flag = status_o[BIT_T_RDY];
   assign any_ready_flag = status_o[BIT_ANY_RDY];
   assign set_p_rdy = p_done_i & cfg_i.pressure_event_enable;
   assign set_t_rdy = t_done_i & cfg_i.temperature_event_enable;
   assign set_any_rdy = (p_done_i | t_done_i) & cfg_i.ready_event_generator_enable;
   assign set_p_ow = set_p_rdy & pressure_ready_flag;
   assign set_t_ow = set_t_rdy & temperature_ready_flag;
   assign set_any_ow = set_any_rdy & any_ready_flag;
   assign clr_p = clr_pressure_i | clr_all_i;
   assign clr_t = clr_temperature_i | clr_all_i;
   assign clr_any = clr_pressure_i | clr_temperature_i | clr_all_i;
   assign next_status[BIT_ANY_OW] = next_flag(status_o[BIT_ANY_OW], set_any_ow, clr_any);
   assign next_status[BIT_P_OW] = next_flag(status_o[BIT_P_OW], set_p_ow, clr_p);
   assign next_status[BIT_T_OW] = next_flag(status_o[BIT_T_OW], set_t_ow, clr_t);
   assign next_status[BIT_RSVD_HI] = 1'b0;
   assign next_status[BIT_ANY_RDY] = next_flag(any_ready_flag, set_any_rdy, clr_any);
   assign next_status[BIT_P_RDY] = next_flag(pressure_ready_flag, set_p_rdy, clr_p);
   assign next_status[BIT_T_RDY] = next_flag(temperature_ready_flag, set_t_rdy, clr_t);
   assign next_status[BIT_RSVD_LO] = 1'b0;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_o <= REG_RESET;
      end else begin
         status_o <= next_status;
      end
   end
endmodule // status_flags

/* sim/host_reader.sv */
`timescale 1ns/1ns
module host_reader
   import sensor_regs_pkg::*;
(
   input wire logic clk_i,
   input wire logic [7:0] rd_data_i,
   input wire logic rd_valid_i,
   input wire logic [7:0] next_addr_i,
   input wire logic queue_pop_i,
   output rd_req_t rd_req_o
);
   initial rd_req_o = '{en: 1'b0, addr: 8'h00};

   // burst of n reads back to back; each later address is the device's own successor
   task automatic burst(input logic [7:0] start, input int n, output logic [7:0] d [0:7],
         output logic [7:0] nxt, output logic pop, output logic ok);
      int k;
      ok = 1'b1;
      pop = 1'b0;
      nxt = 8'h00;
      @(negedge clk_i);
      rd_req_o = '{en: 1'b1, addr: start};
      for (k = 0; k < n; k++) begin
         @(negedge clk_i);
         // latency is fixed at one cycle, so a missing answer is a fault, not a wait
         if (rd_valid_i !== 1'b1) ok = 1'b0;
         d[k] = rd_data_i;
         nxt = next_addr_i;
         pop = queue_pop_i;
         // an idle bus does not keep the last address
         if (k == n - 1) rd_req_o = '{en: 1'b0, addr: ~rd_req_o.addr};
         else rd_req_o = '{en: 1'b1, addr: next_addr_i};
      end
   endtask
endmodule // host_reader

/* sim/tb.sv */
`timescale 1ns/1ns
module tb;
   import sensor_regs_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   rd_req_t rd_req;
   logic [1:0] queue_mode = 2'b00;
   event_flag_config_t cfg = 3'b111;
   logic low_power_idle = 1'b0;
   sample_evt_t sample = '0;
   logic [7:0] queue_status = 8'h00;
   logic [7:0] queue_data = 8'h00;
   logic [7:0] rd_data;
   logic rd_valid;
   logic [7:0] next_addr;
   logic queue_pop;
   logic [7:0] status;
   logic [7:0] got [0:7];
   logic [7:0] nxt;
   logic pop;
   int err_total = 0;
   int compares = 0;

   always #5 clk_i = ~clk_i;

   sample_status_output_regs sample_status_output_regs_i (.clk_i(clk_i), .rst_i(rst_i), .rd_req_i(rd_req),
      .queue_mode_i(queue_mode), .cfg_i(cfg), .low_power_idle_i(low_power_idle), .sample_i(sample),
      .queue_status_i(queue_status), .queue_data_i(queue_data), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
      .next_addr_o(next_addr), .queue_pop_o(queue_pop), .status_o(status));

   host_reader host_reader_i (.clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
      .next_addr_i(next_addr), .queue_pop_i(queue_pop), .rd_req_o(rd_req));

   task automatic conclude;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a, input int n);
      logic ok;
      host_reader_i.burst(a, n, got, nxt, pop, ok);
      check({7'h00, ok}, 8'h01);
      if (ok !== 1'b1) conclude();
   endtask

   task automatic pulse(input logic p, input logic t, input logic [19:0] pv, input logic [11:0] tv,
         input int cycles = 1);
      @(negedge clk_i);
      sample = '{p_done: p, pressure: pv, t_done: t, temperature: tv};
      repeat (cycles) @(negedge clk_i);
      // data lines are not held once the pulse is over
      sample = '{p_done: 1'b0, pressure: ~pv, t_done: 1'b0, temperature: ~tv};
   endtask

   task automatic s_reset;
      int k;
      check(status, 8'h00);
      rd(8'h00, 7);
      for (k = 0; k < 7; k++) check(got[k], 8'h00);
   endtask

   task automatic s_layout;
      logic [7:0] exp [0:6];
      int k;
      exp = '{8'h0e, 8'hab, 8'hcd, 8'he0, 8'h9f, 8'h30, 8'h00};
      pulse(1'b1, 1'b1, 20'ha_bcde, 12'h9f3);
      check(status, 8'h0e);
      rd(8'h00, 7);
      for (k = 0; k < 7; k++) check(got[k], exp[k]);
      check(nxt, 8'h01);
   endtask

   task automatic s_overwrite;
      pulse(1'b1, 1'b0, 20'h1_1111, 12'h000);
      pulse(1'b1, 1'b0, 20'h2_2222, 12'h000);
      check(status, 8'hcc);
      rd(8'h04, 1);
      check(got[0], 8'h9f);
      check(status, 8'h44);
      rd(8'h01, 1);
      check(got[0], 8'h22);
      check({7'h00, pop}, 8'h00);
      check(status, 8'h00);
      pulse(1'b0, 1'b1, 20'h0_0000, 12'h111);
      pulse(1'b0, 1'b1, 20'h0_0000, 12'h222);
      check(status, 8'haa);
      rd(8'h01, 1);
      check(status, 8'h22);
      rd(8'h04, 1);
      check(status, 8'h00);
      // done held for two edges so the second result lands on an unread first one
      pulse(1'b1, 1'b1, 20'h7_7777, 12'h777, 2);
      check(status, 8'hee);
      rd(8'h01, 1);
      check(got[0], 8'h77);
      rd(8'h04, 1);
      check(status, 8'h00);
   endtask

   task automatic s_enables;
      event_flag_config_t cfgs [0:3];
      logic [7:0] exp [0:3];
      int k;
      cfgs = '{3'b000, 3'b100, 3'b010, 3'b001};
      exp = '{8'h00, 8'h44, 8'h22, 8'h88};
      for (k = 0; k < 4; k++) begin
         @(negedge clk_i);
         cfg = cfgs[k];
         pulse(1'b1, 1'b0, 20'h3_3333, 12'h333);
         pulse(1'b1, 1'b1, 20'h4_4444, 12'h444);
         pulse(1'b0, 1'b1, 20'h0_0000, 12'h555);
         check(status, exp[k]);
         rd(8'h01, 1);
         rd(8'h04, 1);
         check(status, 8'h00);
      end
      @(negedge clk_i);
      cfg = 3'b111;
   endtask

   task automatic s_same_cycle;
      fork
         rd(8'h01, 1);
         pulse(1'b1, 1'b0, 20'h1_2345, 12'h000);
      join
      check(status, 8'h0c);
      rd(8'h01, 1);
      check(got[0], 8'h12);
      check(status, 8'h00);
      // a new result one cycle before the low byte read must show in it
      fork
         rd(8'h02, 2);
         pulse(1'b1, 1'b0, 20'h6_789a, 12'h000);
      join
      check(got[0], 8'h34);
      check(got[1], 8'ha0);
      rd(8'h06, 1);
      check(got[0], 8'h0c);
   endtask

   task automatic s_queue;
      logic [1:0] m;
      for (int k = 1; k < 4; k++) begin
         m = 2'(k);
         @(negedge clk_i);
         queue_mode = m;
         queue_status = {6'h14, m};
         queue_data = {6'h30, m};
         pulse(1'b1, 1'b1, 20'h5_5555, 12'h555);
         pulse(1'b1, 1'b1, 20'h6_6666, 12'h666);
         rd(8'h00, 1);
         check(got[0], {6'h14, m});
         check(nxt, 8'h01);
         rd(8'h01, 2);
         check(got[1], {6'h30, m});
         check(nxt, 8'h01);
         check({7'h00, pop}, 8'h01);
         check(status, 8'h00);
         rd(8'h02, 4);
         check(got[0] | got[1] | got[2] | got[3], 8'h00);
         check(nxt, 8'h00);
         rd(8'h0d, 1);
         check(got[0], {6'h14, m});
      end
      @(negedge clk_i);
      queue_mode = 2'b00;
   endtask

   task automatic s_activate;
      int k;
      pulse(1'b1, 1'b1, 20'hf_ffff, 12'hfff);
      rd(8'h02, 1);
      check(got[0], 8'hff);
      @(negedge clk_i);
      low_power_idle = 1'b1;
      repeat (2) @(negedge clk_i);
      low_power_idle = 1'b0;
      @(negedge clk_i);
      check(status, 8'h00);
      check(rd_data, 8'h00);
      rd(8'h01, 5);
      for (k = 0; k < 5; k++) check(got[k], 8'h00);
   endtask

   task automatic s_unmapped;
      rd(8'h20, 1);
      check(got[0], 8'h00);
      check(nxt, 8'h21);
      rd(8'hff, 1);
      check(nxt, 8'h00);
   endtask

   initial begin
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      s_reset();
      s_layout();
      s_overwrite();
      s_enables();
      s_same_cycle();
      s_queue();
      s_activate();
      s_unmapped();
      conclude();
   end
endmodule // tb
